/* File: rtl/pbd_pkg.sv */
// Function
// - device access inside low peripheral window goes to peripheral registers
// - device access outside the window is an ordinary memory access
// - plain load/store in the window goes to external memory, never peripherals
// - each peripheral is a 4K block; low twelve bits address inside it
// - memory interface at 0x2000, diagnostics at 0x3000, 0x4000 up reserved
// - interrupt/low-power, interrupt level, clock/watchdog at 0x20000000 upward
// - serial ports at 0x20004000, 0x20006000; first parallel io at 0x20008000
// - second parallel io 0x2000A000, signal processing 0x2000C000, above reserved
// - lowest 64 Kbytes from 0x80000000 served by on-chip SRAM
// - from 0x81000000 within bank 0 goes to external RAM
// - bank is the signed address quarter, bank 0 lowest, bank 3 highest
// - 16-bit data path, four independently configured static memory banks
// - each bank holds 64 configuration bits as four 16-bit registers
// - after reset every bank holds a slow default configuration
// - one lock per bank; locked bank refuses configuration data writes
// - one status register shows locked and configured per bank
// - sixteen 16-bit data registers on word boundaries, plus locks and status
// - words 0x80000040 to 0x8000013F reserved for trap structures
// - word 0x80000014 reserved as the DMA channel state word
// - at most one active-low chip enable, for the accessed bank of an external access
package pbd_pkg;
    localparam logic [31:0] PBD_PERIPH_END       = 32'h3FFF_FFFF;
    // 4K block numbers, address bits 31:12
    localparam logic [19:0] PBD_BLK_EMI          = 20'h00002;
    localparam logic [19:0] PBD_BLK_DIAG         = 20'h00003;
    localparam logic [19:0] PBD_BLK_INTC         = 20'h20000;
    localparam logic [19:0] PBD_BLK_ILC          = 20'h20001;
    localparam logic [19:0] PBD_BLK_RTC          = 20'h20002;
    localparam logic [19:0] PBD_BLK_SER1         = 20'h20004;
    localparam logic [19:0] PBD_BLK_SER2         = 20'h20006;
    localparam logic [19:0] PBD_BLK_PIO1         = 20'h20008;
    localparam logic [19:0] PBD_BLK_PIO2         = 20'h2000A;
    localparam logic [19:0] PBD_BLK_DSP          = 20'h2000C;
    localparam logic [31:0] PBD_LOWEST_SIGNED    = 32'h8000_0000;
    localparam logic [31:0] PBD_SRAM_END         = 32'h8000_FFFF;
    localparam logic [31:0] PBD_DMA_WORD         = 32'h8000_0014;
    localparam logic [31:0] PBD_TRAP_AREA_BASE   = 32'h8000_0040;
    localparam logic [31:0] PBD_USER_MEMORY_BASE = 32'h8000_0140;
    localparam logic [31:0] PBD_EXT_RAM_BASE     = 32'h8100_0000;
    // register offsets inside the memory interface block
    localparam logic [11:0] PBD_OFS_DATA_END     = 12'h03C;
    localparam logic [11:0] PBD_OFS_LOCK0        = 12'h040;
    localparam logic [11:0] PBD_OFS_LOCK3        = 12'h04C;
    localparam logic [11:0] PBD_OFS_STATUS       = 12'h050;
    // longest access, widest release, 16-bit port
    localparam logic [63:0] PBD_CFG_RESET        = 64'h0FFF_0FFF_0FFF_1811;

    typedef enum logic [2:0] {
        PBD_TGT_NONE, PBD_TGT_PERIPH, PBD_TGT_SRAM,
        PBD_TGT_SYSTEM, PBD_TGT_EXT, PBD_TGT_RSVD
    } pbd_target_t;

    typedef enum logic [3:0] {
        PBD_PER_NONE, PBD_PER_RSVD, PBD_PER_EMI, PBD_PER_DIAG,
        PBD_PER_INTC, PBD_PER_ILC, PBD_PER_RTC, PBD_PER_SER1,
        PBD_PER_SER2, PBD_PER_PIO1, PBD_PER_PIO2, PBD_PER_DSP
    } pbd_periph_t;

    typedef enum logic [1:0] {
        PBD_SYS_NONE, PBD_SYS_DMA, PBD_SYS_TRAP, PBD_SYS_PRIV
    } pbd_sys_t;

    typedef struct packed {
        logic        valid;
        logic        dev;
        logic        write;
        logic [31:0] addr;
        logic [15:0] wdata;
    } pbd_req_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        pbd_target_t target;
        pbd_periph_t periph;
        logic [11:0] offset;
        logic [1:0]  bank;
        pbd_sys_t    sys;
    } pbd_route_t;

    // signed quarters: 0x80000000 is bank 0, 0x40000000 bank 3
    function automatic logic [1:0] pbd_bank_of(input logic [31:0] a);
        return {~a[31], a[30]};
    endfunction
endpackage

/* File: rtl/pbd_periph_map.sv */
`timescale 1ns/1ps
`default_nettype none
module pbd_periph_map
    import pbd_pkg::*;
(
    // address under decode
    input  wire logic [31:0] addr_in,
    // selected 4K block
    output pbd_periph_t      periph_out
);
    logic [19:0] blk;
    assign blk = addr_in[31:12];

    always_comb begin
        if (blk == PBD_BLK_EMI) begin
            periph_out = PBD_PER_EMI;
        end else if (blk == PBD_BLK_DIAG) begin
            periph_out = PBD_PER_DIAG;
        end else if (blk == PBD_BLK_INTC) begin
            periph_out = PBD_PER_INTC;
        end else if (blk == PBD_BLK_ILC) begin
            periph_out = PBD_PER_ILC;
        end else if (blk == PBD_BLK_RTC) begin
            periph_out = PBD_PER_RTC;
        end else if (blk == PBD_BLK_SER1) begin
            periph_out = PBD_PER_SER1;
        end else if (blk == PBD_BLK_SER2) begin
            periph_out = PBD_PER_SER2;
        end else if (blk == PBD_BLK_PIO1) begin
            periph_out = PBD_PER_PIO1;
        end else if (blk == PBD_BLK_PIO2) begin
            periph_out = PBD_PER_PIO2;
        end else if (blk == PBD_BLK_DSP) begin
            periph_out = PBD_PER_DSP;
        end else begin
            // holes between blocks count as reserved too
            periph_out = PBD_PER_RSVD;
        end
    end
endmodule // pbd_periph_map
`default_nettype wire

/* File: rtl/pbd_bank_cfg.sv */
`timescale 1ns/1ps
`default_nettype none
module pbd_bank_cfg
    import pbd_pkg::*;
#(
    parameter logic [63:0] RESET_CFG = PBD_CFG_RESET
) (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // register writes
    input  wire logic        wr_in,
    input  wire logic [1:0]  word_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        lock_in,
    // state
    output logic [63:0]      cfg_out,
    output logic             locked_out,
    output logic             configured_out
);
    logic [3:0][15:0] cfg_q;
    logic             lock_q;
    logic             done_q;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cfg_q <= RESET_CFG;
        end else if (wr_in && !lock_q) begin
            cfg_q[word_in] <= wdata_in;
        end
    end

    // lock is sticky until reset
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            lock_q <= 1'b0;
        end else if (lock_in) begin
            lock_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            done_q <= 1'b0;
        end else if (wr_in && !lock_q) begin
            done_q <= 1'b1;
        end
    end

    assign cfg_out        = cfg_q;
    assign locked_out     = lock_q;
    assign configured_out = done_q;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    chk_locked_cfg_stable: assert property (
        lock_q && wr_in |=> $stable(cfg_q))
        else $error("locked bank configuration changed");
    chk_reset_default_cfg: assert property (
        !done_q |-> cfg_q == RESET_CFG)
        else $error("bank left default without a write");
    chk_lock_sticky: assert property (
        lock_q |=> lock_q)
        else $error("bank lock dropped");
endmodule // pbd_bank_cfg
`default_nettype wire

/* File: rtl/pbd_decode_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pbd_decode_top
    import pbd_pkg::*;
#(
    parameter int NUM_BANKS = 4
) (
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    // processor request
    input  wire pbd_req_t          req_in,
    // routing result
    output pbd_route_t             route_out,
    output logic [3:0]             bank_chip_enable_n_out,
    // locally completed accesses
    output logic                   local_ack_out,
    output logic [15:0]            rdata_out,
    // bank configuration for the strobe logic
    output logic [3:0][63:0]       bank_cfg_out
);
    if (NUM_BANKS != 4) begin : g_bad_banks
        $error("bank select is fixed at four quarters");
    end

    pbd_periph_t      periph_c;
    pbd_target_t      tgt_c;
    pbd_sys_t         sys_c;
    pbd_route_t       route_c;
    pbd_route_t       route_q;
    logic             in_win_c;
    logic [1:0]       bank_c;
    logic [11:0]      ofs_c;
    logic             emi_c;
    logic             rsvd_c;
    logic             aligned_c;
    logic             data_wr_c;
    logic [3:0]       lock_wr_c;
    logic [15:0]      rd_c;
    logic [3:0][63:0] cfg_w;
    logic [3:0]       locked_w;
    logic [3:0]       done_w;
    logic [3:0]       ce_n_q;
    logic             ack_q;
    logic [15:0]      rdata_q;

    pbd_periph_map u_map (
        .addr_in    (req_in.addr),
        .periph_out (periph_c)
    );

    assign in_win_c  = req_in.addr <= PBD_PERIPH_END;
    assign bank_c    = pbd_bank_of(req_in.addr);
    assign ofs_c     = req_in.addr[11:0];
    assign aligned_c = ofs_c[1:0] == 2'h0;

    always_comb begin
        tgt_c = PBD_TGT_NONE;
        sys_c = PBD_SYS_NONE;
        if (!req_in.valid) begin
            tgt_c = PBD_TGT_NONE;
        end else if (req_in.dev && in_win_c) begin
            tgt_c = PBD_TGT_PERIPH;
        end else if (req_in.addr >= PBD_LOWEST_SIGNED &&
                     req_in.addr <= PBD_SRAM_END) begin
            // the bottom words are SRAM too, flagged for the core
            if (req_in.addr < PBD_USER_MEMORY_BASE) begin
                tgt_c = PBD_TGT_SYSTEM;
                if (req_in.addr[31:2] == PBD_DMA_WORD[31:2]) begin
                    sys_c = PBD_SYS_DMA;
                end else if (req_in.addr >= PBD_TRAP_AREA_BASE) begin
                    sys_c = PBD_SYS_TRAP;
                end else begin
                    sys_c = PBD_SYS_PRIV;
                end
            end else begin
                tgt_c = PBD_TGT_SRAM;
            end
        end else if (req_in.addr > PBD_SRAM_END &&
                     req_in.addr < PBD_EXT_RAM_BASE) begin
            // hole above SRAM: no chip enable, nothing driven
            tgt_c = PBD_TGT_RSVD;
        end else begin
            tgt_c = PBD_TGT_EXT;
        end
    end

    always_comb begin
        route_c        = '0;
        route_c.valid  = req_in.valid;
        route_c.write  = req_in.write;
        route_c.target = tgt_c;
        route_c.periph = (tgt_c == PBD_TGT_PERIPH) ? periph_c : PBD_PER_NONE;
        route_c.offset = ofs_c;
        route_c.bank   = bank_c;
        route_c.sys    = sys_c;
    end

    assign emi_c  = tgt_c == PBD_TGT_PERIPH && periph_c == PBD_PER_EMI;
    assign rsvd_c = tgt_c == PBD_TGT_PERIPH && periph_c == PBD_PER_RSVD;

    // memory interface register decode
    always_comb begin
        data_wr_c = 1'b0;
        lock_wr_c = 4'h0;
        rd_c      = 16'h0000;
        if (emi_c && aligned_c) begin
            if (ofs_c <= PBD_OFS_DATA_END) begin
                data_wr_c = req_in.write;
                rd_c = cfg_w[ofs_c[5:4]][{ofs_c[3:2], 4'h0} +: 16];
            end else if (ofs_c >= PBD_OFS_LOCK0 && ofs_c <= PBD_OFS_LOCK3) begin
                lock_wr_c[ofs_c[3:2]] = req_in.write && req_in.wdata[0];
                rd_c = {15'h0000, locked_w[ofs_c[3:2]]};
            end else if (ofs_c == PBD_OFS_STATUS) begin
                rd_c = {8'h00, done_w, locked_w};
            end
        end
    end

    for (genvar b = 0; b < 4; b++) begin : g_bank
        pbd_bank_cfg u_cfg (
            .clk_in         (clk_in),
            .rst_n_in       (rst_n_in),
            .wr_in          (data_wr_c && ofs_c[5:4] == 2'(b)),
            .word_in        (ofs_c[3:2]),
            .wdata_in       (req_in.wdata),
            .lock_in        (lock_wr_c[b]),
            .cfg_out        (cfg_w[b]),
            .locked_out     (locked_w[b]),
            .configured_out (done_w[b])
        );
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            route_q <= '0;
        end else begin
            route_q <= route_c;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ce_n_q <= 4'hF;
        end else if (tgt_c == PBD_TGT_EXT) begin
            ce_n_q <= ~(4'h1 << bank_c);
        end else begin
            ce_n_q <= 4'hF;
        end
    end

    // reserved blocks answer here so the core never hangs
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ack_q   <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            ack_q   <= emi_c || rsvd_c;
            rdata_q <= (emi_c && !req_in.write) ? rd_c : 16'h0000;
        end
    end

    assign route_out              = route_q;
    assign bank_chip_enable_n_out = ce_n_q;
    assign local_ack_out          = ack_q;
    assign rdata_out              = rdata_q;
    assign bank_cfg_out           = cfg_w;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_dev_win;
        req_in.valid && req_in.dev && req_in.addr[31:30] == 2'h0;
    endsequence

    sequence s_cfg_write;
        req_in.valid && req_in.dev && req_in.write &&
        req_in.addr[31:12] == PBD_BLK_EMI && req_in.addr[11:0] == 12'h014 &&
        !locked_w[1];
    endsequence

    sequence s_cfg_read;
        req_in.valid && req_in.dev && !req_in.write &&
        req_in.addr[31:12] == PBD_BLK_EMI && req_in.addr[11:0] == 12'h014;
    endsequence

    chk_periph_route: assert property (
        s_dev_win |=> route_out.target == PBD_TGT_PERIPH &&
                      bank_chip_enable_n_out == 4'hF)
        else $error("device access in window not sent to peripherals");

    chk_dev_outside: assert property (
        req_in.valid && req_in.dev && req_in.addr[31:30] != 2'h0
        |=> route_out.target != PBD_TGT_PERIPH)
        else $error("device access outside window hit peripherals");

    chk_plain_ext: assert property (
        req_in.valid && !req_in.dev && req_in.addr[31:30] == 2'h0
        |=> route_out.target == PBD_TGT_EXT && bank_chip_enable_n_out == 4'hB)
        else $error("plain access in window not sent to bank 2");

    chk_block_offset: assert property (
        s_dev_win |=> route_out.offset == $past(req_in.addr[11:0]))
        else $error("block offset lost");

    chk_emi_block: assert property (
        s_dev_win and req_in.addr[31:12] == 20'h00002
        |=> route_out.periph == PBD_PER_EMI && local_ack_out)
        else $error("memory interface block not selected");

    chk_serial_block: assert property (
        s_dev_win and req_in.addr[31:12] == 20'h20006
        |=> route_out.periph == PBD_PER_SER2)
        else $error("second serial block not selected");

    chk_high_reserved: assert property (
        s_dev_win and req_in.addr[31:12] >= 20'h2000E
        |=> route_out.periph == PBD_PER_RSVD)
        else $error("upper reserved range decoded as a block");

    chk_sram_route: assert property (
        req_in.valid && !req_in.dev && req_in.addr[31:16] == 16'h8000 &&
        req_in.addr[15:0] >= 16'h0140
        |=> route_out.target == PBD_TGT_SRAM && bank_chip_enable_n_out == 4'hF)
        else $error("on-chip SRAM access left the chip");

    chk_ext_ram: assert property (
        req_in.valid && req_in.addr[31:24] == 8'h81
        |=> route_out.target == PBD_TGT_EXT && !bank_chip_enable_n_out[0])
        else $error("external RAM in bank 0 not enabled");

    chk_bank_select: assert property (
        route_out.target == PBD_TGT_EXT
        |-> !bank_chip_enable_n_out[route_out.bank])
        else $error("chip enable does not match bank");

    chk_cfg_readback: assert property (
        s_cfg_write ##1 s_cfg_read
        |=> local_ack_out && rdata_out == $past(req_in.wdata, 2))
        else $error("configuration word not read back");

    chk_status_bits: assert property (
        s_cfg_write |=> ##1 done_w[1])
        else $error("configured bit not set by write");

    chk_trap_area: assert property (
        req_in.valid && !req_in.dev && req_in.addr[31:8] == 24'h800000 &&
        req_in.addr[7:4] >= 4'h4
        |=> route_out.sys == PBD_SYS_TRAP && route_out.target == PBD_TGT_SYSTEM)
        else $error("trap area word not flagged");

    chk_dma_word: assert property (
        req_in.valid && req_in.addr == 32'h8000_0014
        |=> route_out.sys == PBD_SYS_DMA)
        else $error("DMA state word not flagged");

    chk_one_enable: assert property (
        $onehot0(~bank_chip_enable_n_out) &&
        ((bank_chip_enable_n_out != 4'hF) == (route_out.target == PBD_TGT_EXT)))
        else $error("chip enables not one-hot with external target");

    chk_rsvd_zero: assert property (
        s_dev_win and req_in.addr[31:12] == 20'h00004
        |=> local_ack_out && rdata_out == 16'h0000 && $stable(cfg_w))
        else $error("reserved access had an effect");

    sequence s_lock_write;
        req_in.valid && req_in.dev && req_in.write && req_in.wdata[0] &&
        req_in.addr[31:12] == PBD_BLK_EMI && req_in.addr[11:0] == 12'h044;
    endsequence

    chk_lock_set: assert property (
        s_lock_write |=> locked_w[1] && local_ack_out)
        else $error("bank lock not set by lock write");

    chk_diag_block: assert property (
        s_dev_win and req_in.addr[31:12] == 20'h00003
        |=> route_out.periph == PBD_PER_DIAG)
        else $error("diagnostic block not selected");

    chk_intc_block: assert property (
        s_dev_win and req_in.addr[31:12] == 20'h20000
        |=> route_out.periph == PBD_PER_INTC)
        else $error("interrupt controller block not selected");

    chk_rtc_block: assert property (
        s_dev_win and req_in.addr[31:12] == 20'h20002
        |=> route_out.periph == PBD_PER_RTC)
        else $error("clock and watchdog block not selected");

    chk_pio_block: assert property (
        s_dev_win and req_in.addr[31:12] == 20'h20008
        |=> route_out.periph == PBD_PER_PIO1)
        else $error("first parallel io block not selected");

    chk_dsp_block: assert property (
        s_dev_win and req_in.addr[31:12] == 20'h2000C
        |=> route_out.periph == PBD_PER_DSP)
        else $error("signal processing block not selected");

    chk_plain_no_effect: assert property (
        req_in.valid && !req_in.dev
        |=> !local_ack_out && route_out.periph == PBD_PER_NONE && $stable(cfg_w))
        else $error("plain access reached peripheral registers");

    chk_unaligned_cfg: assert property (
        req_in.valid && req_in.dev && req_in.addr[31:12] == PBD_BLK_EMI && req_in.addr[1:0] != 2'h0
        |=> $stable(cfg_w))
        else $error("unaligned access changed a configuration word");

    chk_mem_gap: assert property (
        req_in.valid && req_in.addr[31:24] == 8'h80 && req_in.addr[23:16] != 8'h00
        |=> route_out.target == PBD_TGT_RSVD && bank_chip_enable_n_out == 4'hF)
        else $error("gap below external RAM enabled a bank");

    chk_idle_quiet: assert property (
        !req_in.valid
        |=> !route_out.valid && !local_ack_out && bank_chip_enable_n_out == 4'hF)
        else $error("outputs active without a request");
endmodule // pbd_decode_top
`default_nettype wire

/* File: bench/pbd_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pbd_core_model
    import pbd_pkg::*;
(
    // clock
    input  wire logic clk_in,
    // request towards the decoder
    output var pbd_req_t req_out
);
    initial req_out = '0;

    // one request held across exactly one rising edge
    task automatic issue(input logic dev, input logic wr, input logic [31:0] addr, input logic [15:0] wd);
        @(negedge clk_in);
        req_out <= '{valid: 1'b1, dev: dev, write: wr, addr: addr, wdata: wd};
        @(negedge clk_in);
        // released lines show the inverse so a stale copy is never mistaken for a request
        req_out <= '{valid: 1'b0, dev: ~dev, write: ~wr, addr: ~addr, wdata: ~wd};
    endtask

    // a store and its read-back on consecutive rising edges, no idle cycle between
    task automatic issue_pair(input logic [31:0] addr, input logic [15:0] wd);
        @(negedge clk_in);
        req_out <= '{valid: 1'b1, dev: 1'b1, write: 1'b1, addr: addr, wdata: wd};
        @(negedge clk_in);
        req_out <= '{valid: 1'b1, dev: 1'b1, write: 1'b0, addr: addr, wdata: ~wd};
        @(negedge clk_in);
        req_out <= '{valid: 1'b0, dev: 1'b0, write: 1'b1, addr: ~addr, wdata: wd};
    endtask
endmodule // pbd_core_model
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
    import pbd_pkg::*;
;
    typedef struct packed {
        logic        dev;
        logic [31:0] addr;
        pbd_target_t tgt;
        logic [3:0]  ce_n;
        pbd_sys_t    sys;
    } pbd_tb_case_t;

    logic             clk_in   = 1'b0;
    logic             rst_n_in = 1'b0;
    pbd_req_t         req;
    pbd_route_t       route;
    logic [3:0]       ce_n;
    logic             ack;
    logic [15:0]      rdata;
    logic [3:0][63:0] cfg;
    int               fail_count = 0;
    int               checked    = 0;

    always #50 clk_in = ~clk_in;

    pbd_core_model core (.clk_in(clk_in), .req_out(req));
    pbd_decode_top #(.NUM_BANKS(4)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req), .route_out(route),
        .bank_chip_enable_n_out(ce_n), .local_ack_out(ack), .rdata_out(rdata), .bank_cfg_out(cfg));

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        checked++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic do_reset();
        @(negedge clk_in);
        rst_n_in <= 1'b0;
        repeat (4) @(negedge clk_in);
        chk("idle route", 64'h0, 64'(route));
        chk("idle enables", 64'hF, ce_n);
        chk("idle ack", 64'h0, ack);
        for (int b = 0; b < 4; b++) begin
            chk("default config", PBD_CFG_RESET, cfg[b]);
        end
        rst_n_in <= 1'b1;
        core.issue(1'b1, 1'b0, 32'h0000_2050, 16'h0000);
        chk("status", 64'h0, rdata);
    endtask

    task automatic check_bank_config();
        logic [63:0] exp [4];
        for (int b = 0; b < 4; b++) begin
            for (int k = 0; k < 4; k++) begin
                exp[b][16*k +: 16] = 16'hC000 | 16'(b * 16 + k);
                core.issue(1'b1, 1'b1, 32'h0000_2000 + 32'(b * 16 + k * 4), exp[b][16*k +: 16]);
                chk("write ack", 64'h1, ack);
            end
            chk("bank config", exp[b], cfg[b]);
        end
        for (int i = 0; i < 16; i++) begin
            core.issue(1'b1, 1'b0, 32'h0000_2000 + 32'(i * 4), 16'h0000);
            chk("read back", 64'(exp[i / 4][16 * (i % 4) +: 16]), rdata);
        end
        core.issue(1'b1, 1'b0, 32'h0000_2050, 16'h0000);
        chk("status", 64'h00F0, rdata);
        core.issue(1'b1, 1'b1, 32'h0000_2044, 16'h0001);
        core.issue(1'b1, 1'b1, 32'h0000_2010, 16'h5555);
        chk("locked ack", 64'h1, ack);
        chk("locked bank", exp[1], cfg[1]);
        exp[2][15:0] = 16'h5555;
        core.issue(1'b1, 1'b1, 32'h0000_2020, 16'h5555);
        chk("open bank", exp[2], cfg[2]);
        core.issue(1'b1, 1'b0, 32'h0000_2044, 16'h0000);
        chk("lock read", 64'h1, rdata);
        core.issue(1'b1, 1'b0, 32'h0000_2050, 16'h0000);
        chk("status", 64'h00F2, rdata);
        // unaligned, reserved-block and plain stores must all leave the banks alone
        core.issue(1'b1, 1'b1, 32'h0000_2002, 16'hFFFF);
        chk("unaligned write", exp[0], cfg[0]);
        core.issue(1'b1, 1'b1, 32'h0000_0010, 16'hFFFF);
        chk("reserved ack", 64'h1, ack);
        chk("reserved write", exp[1], cfg[1]);
        core.issue(1'b0, 1'b1, 32'h0000_2024, 16'hFFFF);
        chk("plain store ack", 64'h0, ack);
        chk("plain store", exp[2], cfg[2]);
    endtask

    task automatic check_periph_map();
        logic [31:0] a [15] = '{32'h0000_0000, 32'h0000_2000, 32'h0000_3FFC, 32'h0000_4000, 32'h2000_0000,
            32'h2000_1000, 32'h2000_2FFC, 32'h2000_3000, 32'h2000_4000, 32'h2000_6000, 32'h2000_8000,
            32'h2000_A000, 32'h2000_CFFC, 32'h2000_E000, 32'h3FFF_F000};
        pbd_periph_t p [15] = '{PBD_PER_RSVD, PBD_PER_EMI, PBD_PER_DIAG, PBD_PER_RSVD, PBD_PER_INTC, PBD_PER_ILC,
            PBD_PER_RTC, PBD_PER_RSVD, PBD_PER_SER1, PBD_PER_SER2, PBD_PER_PIO1, PBD_PER_PIO2, PBD_PER_DSP,
            PBD_PER_RSVD, PBD_PER_RSVD};
        for (int i = 0; i < 15; i++) begin
            core.issue(1'b1, 1'b0, a[i], 16'h0000);
            chk("target", 64'(PBD_TGT_PERIPH), 64'(route.target));
            chk("block", 64'(p[i]), 64'(route.periph));
            chk("offset", 64'(a[i][11:0]), 64'(route.offset));
            chk("chip enables", 64'hF, ce_n);
            chk("local ack", 64'(p[i] == PBD_PER_RSVD || p[i] == PBD_PER_EMI), ack);
            if (p[i] == PBD_PER_RSVD)
                chk("reserved read", 64'h0, rdata);
        end
    endtask

    task automatic check_routes();
        pbd_tb_case_t c [13] = '{
            '{1'b0, 32'h0000_0100, PBD_TGT_EXT, 4'hB, PBD_SYS_NONE}, '{1'b1, 32'h4000_0000, PBD_TGT_EXT, 4'h7, PBD_SYS_NONE},
            '{1'b1, 32'h7FFF_FFFC, PBD_TGT_EXT, 4'h7, PBD_SYS_NONE}, '{1'b0, 32'hC000_0000, PBD_TGT_EXT, 4'hD, PBD_SYS_NONE},
            '{1'b0, 32'hBFFF_FFFC, PBD_TGT_EXT, 4'hE, PBD_SYS_NONE}, '{1'b0, 32'h8100_0000, PBD_TGT_EXT, 4'hE, PBD_SYS_NONE},
            '{1'b0, 32'h8000_0140, PBD_TGT_SRAM, 4'hF, PBD_SYS_NONE}, '{1'b1, 32'h8000_FFFC, PBD_TGT_SRAM, 4'hF, PBD_SYS_NONE},
            '{1'b0, 32'h8001_0000, PBD_TGT_RSVD, 4'hF, PBD_SYS_NONE}, '{1'b0, 32'h8000_0014, PBD_TGT_SYSTEM, 4'hF, PBD_SYS_DMA},
            '{1'b0, 32'h8000_0040, PBD_TGT_SYSTEM, 4'hF, PBD_SYS_TRAP}, '{1'b0, 32'h8000_013C, PBD_TGT_SYSTEM, 4'hF, PBD_SYS_TRAP},
            '{1'b0, 32'h8000_0010, PBD_TGT_SYSTEM, 4'hF, PBD_SYS_PRIV}};
        // banks were programmed above before any access reaches them
        for (int i = 0; i < 13; i++) begin
            core.issue(c[i].dev, 1'(i % 2), c[i].addr, 16'h0000);
            chk("route target", 64'(c[i].tgt), 64'(route.target));
            chk("route write", 64'(i % 2), 64'(route.write));
            chk("route valid", 64'h1, 64'(route.valid));
            chk("chip enables", c[i].ce_n, ce_n);
            if (c[i].tgt == PBD_TGT_EXT)
                chk("bank", 64'(4'hF ^ c[i].ce_n), 64'(4'h1 << route.bank));
            if (c[i].tgt == PBD_TGT_SYSTEM)
                chk("system word", 64'(c[i].sys), 64'(route.sys));
        end
        @(negedge clk_in);
        chk("released valid", 64'h0, route.valid);
        chk("released enables", 64'hF, ce_n);
    endtask

    task automatic check_back_to_back();
        core.issue_pair(32'h0000_2014, 16'h1234);
        chk("back to back ack", 64'h1, 64'(ack));
        chk("back to back read", 64'h1234, 64'(rdata));
        chk("back to back config", 64'h1234, 64'(cfg[1][31:16]));
    endtask

    initial begin
        do_reset();
        check_bank_config();
        check_periph_map();
        check_routes();
        // mid-run reset must restore the slow defaults and clear locks
        do_reset();
        check_back_to_back();
        give_verdict();
    end

    initial begin
        repeat (5000) @(posedge clk_in);
        fail_count++;
        give_verdict();
    end
endmodule // tb
`default_nettype wire
